// ===== rtl/hsrp_device.sv
// device end: spi slave, register array, baud divider and uart transmitter
`timescale 1ns/10ps
module hsrp_device
  import hsrp_pkg::*;
(
  // clock and reset
  input  wire logic        SYS_CLK,
  input  wire logic        RST_N,
  // serial link
  hsrp_spi_if.device       SPI,
  // uart character input
  input  wire logic        TX_VALID,
  input  wire logic [7:0]  TX_DATA,
  output logic             TX_READY,
  // uart pins
  output logic             UART_TX,
  output logic             UART_DATA_REQUEST,
  output logic             UART_MUX_OUTPUT,
  output logic             BAUD_TICK,
  // register write report
  output logic             REG_WR_STROBE,
  output logic [5:0]       REG_WR_ADDR,
  output logic [7:0]       REG_WR_DATA
);

  logic [7:0]      regs_q [REG_COUNT];
  logic            sck_q;
  logic [2:0]      bit_q;
  logic [6:0]      rx_sh_q;
  logic [7:0]      tx_sh_q;
  logic            miso_q;
  logic [5:0]      addr_q;
  hsrp_dev_phase_e ph_q;

  logic       sck_rise;
  logic       sck_fall;
  logic [7:0] rx_byte;
  logic       byte_done;
  logic       wr_now;
  logic       load_rd;

  // sck is sampled as a plain synchronous input, so the link tops out at
  // half the system clock; faster links need a faster system clock
  assign sck_rise  = SPI.sck & ~sck_q;
  assign sck_fall  = ~SPI.sck & sck_q;
  assign rx_byte   = {rx_sh_q, SPI.mosi};
  assign byte_done = ~SPI.cs_n & sck_rise & (bit_q == 3'h7);
  assign wr_now    = byte_done & (ph_q == DEV_PH_WRITE);
  assign load_rd   = byte_done & ((ph_q == DEV_PH_READ) |
                     ((ph_q == DEV_PH_ADDR) & (rx_byte[SPI_DIR_BIT] == SPI_DIR_READ)));

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      sck_q <= 1'b0;
    end else begin
      sck_q <= SPI.sck;
    end
  end

  // receive side: mosi taken on rising sck
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      bit_q   <= 3'h0;
      rx_sh_q <= 7'h00;
      addr_q  <= 6'h00;
      ph_q    <= DEV_PH_ADDR;
    end else if (SPI.cs_n) begin
      bit_q <= 3'h0;
      ph_q  <= DEV_PH_ADDR;
    end else if (sck_rise) begin
      rx_sh_q <= rx_byte[6:0];
      bit_q   <= bit_q + 3'h1;
      if (bit_q == 3'h7) begin
        case (ph_q)
          DEV_PH_ADDR: begin
            // bit 0 of the address byte is ignored
            addr_q <= rx_byte[SPI_ADDR_MSB:SPI_ADDR_LSB];
            ph_q   <= (rx_byte[SPI_DIR_BIT] == SPI_DIR_READ) ? DEV_PH_READ : DEV_PH_WRITE;
          end
          DEV_PH_READ: begin
            // every byte of a read is the next address; the closing 00 is harmless
            addr_q <= rx_byte[SPI_ADDR_MSB:SPI_ADDR_LSB];
          end
          default: begin
            ph_q <= DEV_PH_WRITE;
          end
        endcase
      end
    end
  end

  // transmit side: loaded at byte end, shifted out on falling sck
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      tx_sh_q <= 8'h00;
      miso_q  <= 1'b0;
    end else if (load_rd) begin
      tx_sh_q <= regs_q[rx_byte[SPI_ADDR_MSB:SPI_ADDR_LSB]];
    end else if (~SPI.cs_n & sck_fall) begin
      miso_q  <= tx_sh_q[7];
      tx_sh_q <= {tx_sh_q[6:0], 1'b0};
    end
  end

  assign SPI.miso_o  = miso_q;
  assign SPI.miso_oe = ~SPI.cs_n;

  // register array; all bytes of a write land at the one address
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      for (int i = 0; i < REG_COUNT; i++) begin
        regs_q[i] <= (i == int'(BAUD_DIV_ADDR)) ? BAUD_DIV_RST :
                     (i == int'(TEST_PIN_EN_ADDR)) ? TEST_PIN_EN_RST : 8'h00;
      end
    end else if (wr_now) begin
      regs_q[addr_q] <= rx_byte;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      REG_WR_STROBE <= 1'b0;
      REG_WR_ADDR   <= 6'h00;
      REG_WR_DATA   <= 8'h00;
    end else begin
      REG_WR_STROBE <= wr_now;
      if (wr_now) begin
        REG_WR_ADDR <= addr_q;
        REG_WR_DATA <= rx_byte;
      end
    end
  end

  // baud generator: bit period in reference ticks
  logic [2:0]  baud_exponent;
  logic [4:0]  baud_mantissa;
  logic [12:0] bit_period;
  logic [23:0] acc_q;
  logic [23:0] acc_sum;
  logic [23:0] acc_thr;

  assign baud_exponent = regs_q[BAUD_DIV_ADDR][BAUD_EXP_MSB:BAUD_EXP_LSB];
  assign baud_mantissa = regs_q[BAUD_DIV_ADDR][BAUD_MANT_MSB:BAUD_MANT_LSB];

  always_comb begin
    if (baud_exponent == 3'h0) begin
      bit_period = 13'(baud_mantissa) + BAUD_MANT_OFS_LOW;
    end else begin
      bit_period = (13'(baud_mantissa) + BAUD_MANT_OFS_HIGH) << (baud_exponent - 3'h1);
    end
  end

  // fractional accumulation keeps the average rate exact, so the error of
  // the listed settings stays that of the divider itself; jitter is one cycle
  assign acc_sum = acc_q + BAUD_ACC_STEP;
  // widen before the product: a long period times the unit overflows 13 bits
  assign acc_thr = 24'(bit_period) * BAUD_ACC_UNIT;

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      acc_q     <= 24'h000000;
      BAUD_TICK <= 1'b0;
    end else if (acc_sum >= acc_thr) begin
      acc_q     <= acc_sum - acc_thr;
      BAUD_TICK <= 1'b1;
    end else begin
      acc_q     <= acc_sum;
      BAUD_TICK <= 1'b0;
    end
  end

  // uart transmitter
  logic [9:0] frame_q;
  logic [3:0] tx_cnt_q;
  logic       tx_busy_q;
  logic       line_q;
  logic       serial_line_enable;

  assign TX_READY           = ~tx_busy_q;
  assign serial_line_enable = regs_q[TEST_PIN_EN_ADDR][SERIAL_LINE_EN_BIT];

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      frame_q   <= 10'h3ff;
      tx_cnt_q  <= 4'h0;
      tx_busy_q <= 1'b0;
      line_q    <= 1'b1;
    end else if (!tx_busy_q) begin
      if (TX_VALID) begin
        frame_q   <= {1'b1, TX_DATA, 1'b0};
        tx_cnt_q  <= 4'h0;
        tx_busy_q <= 1'b1;
      end
    end else if (BAUD_TICK) begin
      if (tx_cnt_q == UART_FRAME_BITS) begin
        tx_busy_q <= 1'b0;
        line_q    <= 1'b1;
      end else begin
        line_q   <= frame_q[0];
        frame_q  <= {1'b1, frame_q[9:1]};
        tx_cnt_q <= tx_cnt_q + 4'h1;
      end
    end
  end

  assign UART_TX = line_q;

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      UART_DATA_REQUEST <= 1'b0;
      UART_MUX_OUTPUT   <= 1'b0;
    end else begin
      UART_DATA_REQUEST <= serial_line_enable & ~tx_busy_q;
      UART_MUX_OUTPUT   <= serial_line_enable & line_q;
    end
  end

endmodule

// ===== common/hsrp_pkg.sv
// shared constants and types of the host serial register port
package hsrp_pkg;

  // clocks and rates
  localparam int SYS_CLK_HZ   = 10000000;
  localparam int REF_CLK_HZ   = 27120000;
  localparam int SPI_MAX_BPS  = 10000000;
  // sck half period in system cycles, a shortest time, never below one
  localparam int SPI_SCK_HALF_CYC = (SYS_CLK_HZ / (2 * SPI_MAX_BPS)) < 1 ? 1 : (SYS_CLK_HZ / (2 * SPI_MAX_BPS));

  // fractional baud accumulator: ref ticks per system cycle, scaled
  localparam int BAUD_SCALE      = 10000;
  localparam logic [23:0] BAUD_ACC_STEP = 24'(REF_CLK_HZ / BAUD_SCALE);
  localparam logic [23:0] BAUD_ACC_UNIT = 24'(SYS_CLK_HZ / BAUD_SCALE);

  // spi address byte layout
  localparam int SPI_DIR_BIT    = 7;
  localparam int SPI_ADDR_MSB   = 6;
  localparam int SPI_ADDR_LSB   = 1;
  localparam logic SPI_DIR_READ = 1'b1;

  // device register map (six-bit addresses)
  localparam int REG_COUNT               = 64;
  localparam logic [5:0] BAUD_DIV_ADDR   = 6'h1f;
  localparam logic [5:0] TEST_PIN_EN_ADDR = 6'h33;
  localparam logic [7:0] BAUD_DIV_RST    = 8'heb;
  localparam logic [7:0] TEST_PIN_EN_RST = 8'h80;
  localparam int SERIAL_LINE_EN_BIT      = 7;
  localparam int BAUD_EXP_MSB  = 7;
  localparam int BAUD_EXP_LSB  = 5;
  localparam int BAUD_MANT_MSB = 4;
  localparam int BAUD_MANT_LSB = 0;
  localparam logic [12:0] BAUD_MANT_OFS_LOW  = 13'h0001;
  localparam logic [12:0] BAUD_MANT_OFS_HIGH = 13'h0021;

  // uart framing: start, eight data, stop
  localparam logic [3:0] UART_FRAME_BITS = 4'ha;

  // host controller register indices
  localparam logic [1:0] HOST_DATA_IDX   = 2'h0;
  localparam logic [1:0] HOST_CTRL_IDX   = 2'h1;
  localparam logic [1:0] HOST_STATUS_IDX = 2'h2;
  localparam int HOST_CTRL_KEEP_BIT  = 0;
  localparam int HOST_STAT_BUSY_BIT  = 0;
  localparam int HOST_STAT_SEL_BIT   = 1;

  typedef enum logic [1:0] {
    DEV_PH_ADDR,
    DEV_PH_READ,
    DEV_PH_WRITE
  } hsrp_dev_phase_e;

  typedef enum logic [1:0] {
    HOST_IDLE,
    HOST_LOW,
    HOST_HIGH
  } hsrp_host_state_e;

endpackage

// ===== common/hsrp_spi_if.sv
// serial link between host controller and device
`timescale 1ns/10ps
interface hsrp_spi_if;
  logic sck;
  logic cs_n;
  logic mosi;
  logic miso_o;
  logic miso_oe;
  logic miso;

  // released line reads high, as with a pull-up
  assign miso = miso_oe ? miso_o : 1'b1;

  modport device (
    input  sck,
    input  cs_n,
    input  mosi,
    output miso_o,
    output miso_oe
  );

  modport host (
    output sck,
    output cs_n,
    output mosi,
    input  miso
  );
endinterface

// ===== rtl/hsrp_host.sv
// host end: spi master driven byte by byte from a small register port
`timescale 1ns/10ps
module hsrp_host
  import hsrp_pkg::*;
#(
  parameter int SCK_HALF = SPI_SCK_HALF_CYC
)(
  // clock and reset
  input  wire logic        SYS_CLK,
  input  wire logic        RST_N,
  // serial link
  hsrp_spi_if.host         SPI,
  // register port
  input  wire logic [1:0]  REG_ADDR,
  input  wire logic [7:0]  REG_WDATA,
  input  wire logic        REG_WR,
  input  wire logic        REG_RD,
  output logic [7:0]       REG_RDATA
);

  hsrp_host_state_e st_q;
  logic [7:0]       tx_sh_q;
  logic [7:0]       rx_sh_q;
  logic [7:0]       rx_last_q;
  logic [2:0]       bit_q;
  logic [7:0]       cnt_q;
  logic             keep_q;
  logic             sck_q;
  logic             cs_n_q;
  logic             mosi_q;
  logic             half_end;
  logic             start;

  assign half_end = (cnt_q == 8'(SCK_HALF - 1));
  // a data write while busy is dropped
  assign start    = REG_WR & (REG_ADDR == HOST_DATA_IDX) & (st_q == HOST_IDLE);

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      keep_q <= 1'b0;
    end else if (REG_WR && REG_ADDR == HOST_CTRL_IDX) begin
      keep_q <= REG_WDATA[HOST_CTRL_KEEP_BIT];
    end
  end

  // sck idles low; mosi moves with the falling edge, miso taken at the
  // end of the high phase where the device value has settled
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      st_q      <= HOST_IDLE;
      tx_sh_q   <= 8'h00;
      rx_sh_q   <= 8'h00;
      rx_last_q <= 8'h00;
      bit_q     <= 3'h0;
      cnt_q     <= 8'h00;
      sck_q     <= 1'b0;
      cs_n_q    <= 1'b1;
      mosi_q    <= 1'b0;
    end else begin
      case (st_q)
        HOST_IDLE: begin
          if (start) begin
            cs_n_q  <= 1'b0;
            mosi_q  <= REG_WDATA[7];
            tx_sh_q <= {REG_WDATA[6:0], 1'b0};
            bit_q   <= 3'h0;
            cnt_q   <= 8'h00;
            st_q    <= HOST_LOW;
          end else if (REG_WR && REG_ADDR == HOST_CTRL_IDX && !REG_WDATA[HOST_CTRL_KEEP_BIT]) begin
            cs_n_q <= 1'b1;
          end
        end
        HOST_LOW: begin
          if (half_end) begin
            sck_q <= 1'b1;
            cnt_q <= 8'h00;
            st_q  <= HOST_HIGH;
          end else begin
            cnt_q <= cnt_q + 8'h01;
          end
        end
        default: begin
          if (half_end) begin
            sck_q   <= 1'b0;
            cnt_q   <= 8'h00;
            rx_sh_q <= {rx_sh_q[6:0], SPI.miso};
            bit_q   <= bit_q + 3'h1;
            if (bit_q == 3'h7) begin
              rx_last_q <= {rx_sh_q[6:0], SPI.miso};
              cs_n_q    <= ~keep_q;
              st_q      <= HOST_IDLE;
            end else begin
              mosi_q  <= tx_sh_q[7];
              tx_sh_q <= {tx_sh_q[6:0], 1'b0};
              st_q    <= HOST_LOW;
            end
          end else begin
            cnt_q <= cnt_q + 8'h01;
          end
        end
      endcase
    end
  end

  assign SPI.sck  = sck_q;
  assign SPI.cs_n = cs_n_q;
  assign SPI.mosi = mosi_q;

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      REG_RDATA <= 8'h00;
    end else if (REG_RD) begin
      if (REG_ADDR == HOST_DATA_IDX) begin
        REG_RDATA <= rx_last_q;
      end else if (REG_ADDR == HOST_CTRL_IDX) begin
        REG_RDATA <= {7'h00, keep_q};
      end else if (REG_ADDR == HOST_STATUS_IDX) begin
        REG_RDATA <= {6'h00, ~cs_n_q, st_q != HOST_IDLE};
      end else begin
        REG_RDATA <= 8'h00;
      end
    end else begin
      REG_RDATA <= 8'h00;
    end
  end

endmodule

// ===== testbench/hsrp_monitor.sv
// concurrent checks on the serial link between host and device
`timescale 1ns/10ps
module hsrp_monitor (
  // clock and reset
  input wire logic SYS_CLK,
  input wire logic RST_N,
  // serial link
  input wire logic sck,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic miso_o,
  input wire logic miso_oe,
  input wire logic miso
);
  logic       sck_q;
  logic [2:0] rise_cnt_q;

  // sck rises within one selection, modulo a byte
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      sck_q      <= 1'b0;
      rise_cnt_q <= 3'h0;
    end else begin
      sck_q <= sck;
      if (cs_n) begin
        rise_cnt_q <= 3'h0;
      end else if (sck && !sck_q) begin
        rise_cnt_q <= rise_cnt_q + 3'h1;
      end
    end
  end

  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);

  sequence s_first_clock;
    !sck ##1 sck;
  endsequence

  property p_sel_start;   $fell(cs_n) |-> s_first_clock; endproperty
  property p_sck_pulse;   $rose(sck) |=> !sck; endproperty
  property p_mosi_edge;   $changed(mosi) |-> !sck; endproperty
  property p_idle_sck;    cs_n |-> !sck; endproperty
  property p_byte_whole;  $rose(cs_n) |-> rise_cnt_q == 3'h0; endproperty
  property p_oe_sel;      miso_oe == !cs_n; endproperty
  property p_miso_idle;   cs_n |-> miso; endproperty
  property p_sck_sel;     $rose(sck) |-> $past(cs_n) == 1'b0; endproperty
  // device moves its data only one cycle after it has seen sck fall
  property p_miso_fall;   $changed(miso_o) |-> !$past(sck) && $past(sck_q); endproperty

  a_sel_start:  assert property (p_sel_start) else $error("sck did not start low then high");
  a_sck_pulse:  assert property (p_sck_pulse) else $error("sck high longer than one cycle");
  a_mosi_edge:  assert property (p_mosi_edge) else $error("mosi changed while sck high");
  a_idle_sck:   assert property (p_idle_sck) else $error("sck high while deselected");
  a_byte_whole: assert property (p_byte_whole) else $error("selection ended mid byte");
  a_oe_sel:     assert property (p_oe_sel) else $error("miso drive differs from select");
  a_miso_idle:  assert property (p_miso_idle) else $error("miso not released");
  a_sck_sel:    assert property (p_sck_sel) else $error("sck rose without select");
  a_miso_fall:  assert property (p_miso_fall) else $error("miso changed away from falling sck");
endmodule

// ===== testbench/tb.sv
// self-checking bench: host and device joined over the serial link
`timescale 1ns/10ps
module tb;
  import hsrp_pkg::*;
  logic       SYS_CLK   = 1'b0;
  logic       RST_N     = 1'b0;
  logic [1:0] REG_ADDR  = 2'h0;
  logic [7:0] REG_WDATA = 8'h00;
  logic       REG_WR    = 1'b0;
  logic       REG_RD    = 1'b0;
  logic       TX_VALID  = 1'b0;
  logic [7:0] TX_DATA   = 8'h00;
  logic [7:0] REG_RDATA;
  logic       TX_READY, UART_TX, UART_DATA_REQUEST, UART_MUX_OUTPUT, BAUD_TICK, REG_WR_STROBE;
  logic [5:0] REG_WR_ADDR;
  logic [7:0] REG_WR_DATA;
  logic [7:0] wire_sr;
  int         fail_count = 0;
  int         n_compared = 0;
  int         n_strobe   = 0;

  hsrp_spi_if u_hsrp_spi_if ();
  hsrp_host u_hsrp_host (.SYS_CLK(SYS_CLK), .RST_N(RST_N), .SPI(u_hsrp_spi_if), .REG_ADDR(REG_ADDR),
    .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA));
  hsrp_device u_hsrp_device (.SYS_CLK(SYS_CLK), .RST_N(RST_N), .SPI(u_hsrp_spi_if), .TX_VALID(TX_VALID),
    .TX_DATA(TX_DATA), .TX_READY(TX_READY), .UART_TX(UART_TX), .UART_DATA_REQUEST(UART_DATA_REQUEST),
    .UART_MUX_OUTPUT(UART_MUX_OUTPUT), .BAUD_TICK(BAUD_TICK), .REG_WR_STROBE(REG_WR_STROBE),
    .REG_WR_ADDR(REG_WR_ADDR), .REG_WR_DATA(REG_WR_DATA));
  hsrp_monitor u_hsrp_monitor (.SYS_CLK(SYS_CLK), .RST_N(RST_N), .sck(u_hsrp_spi_if.sck),
    .cs_n(u_hsrp_spi_if.cs_n), .mosi(u_hsrp_spi_if.mosi), .miso_o(u_hsrp_spi_if.miso_o),
    .miso_oe(u_hsrp_spi_if.miso_oe), .miso(u_hsrp_spi_if.miso));

  always #50 SYS_CLK = ~SYS_CLK;
  // what actually crossed the wire, sampled where the device samples
  always @(posedge u_hsrp_spi_if.sck) wire_sr <= {wire_sr[6:0], u_hsrp_spi_if.mosi};
  always @(posedge SYS_CLK) if (REG_WR_STROBE === 1'b1) n_strobe++;

  task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", name, exp, got);
      fail_count++;
    end
  endtask

  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge SYS_CLK);
    REG_ADDR  <= a;
    REG_WDATA <= d;
    REG_WR    <= 1'b1;
    @(posedge SYS_CLK);
    REG_WR    <= 1'b0;
  endtask

  task automatic rd(input logic [1:0] a, output logic [7:0] d);
    @(posedge SYS_CLK);
    REG_ADDR <= a;
    REG_RD   <= 1'b1;
    @(posedge SYS_CLK);
    REG_RD   <= 1'b0;
    @(negedge SYS_CLK);
    d = REG_RDATA;
  endtask

  // one byte slot; select is opened and closed by the caller
  task automatic xfer(input logic [7:0] b, output logic [7:0] r);
    logic [7:0] st;
    int         i;
    wr(HOST_DATA_IDX, b);
    st = 8'h01;
    for (i = 0; i < 40 && st[HOST_STAT_BUSY_BIT] !== 1'b0; i++) rd(HOST_STATUS_IDX, st);
    check("busy", 16'h0, {15'h0, st[HOST_STAT_BUSY_BIT]});
    check("mosi", {8'h0, b}, {8'h0, wire_sr});
    rd(HOST_DATA_IDX, r);
  endtask

  task automatic dev_wr(input logic [5:0] a, input logic [7:0] d);
    logic [7:0] r;
    wr(HOST_CTRL_IDX, 8'h01);
    xfer({~SPI_DIR_READ, a, 1'b0}, r);
    xfer(d, r);
    wr(HOST_CTRL_IDX, 8'h00);
  endtask

  task automatic dev_rd(input logic [5:0] a, output logic [7:0] d);
    wr(HOST_CTRL_IDX, 8'h01);
    xfer({SPI_DIR_READ, a, 1'b0}, d);
    xfer(8'h00, d);
    wr(HOST_CTRL_IDX, 8'h00);
  endtask

  task automatic t_read_reset;
    logic [7:0] r;
    wr(HOST_CTRL_IDX, 8'h01);
    xfer({SPI_DIR_READ, BAUD_DIV_ADDR, 1'b0}, r);
    xfer({SPI_DIR_READ, TEST_PIN_EN_ADDR, 1'b0}, r);
    check("baud divider", 16'h00eb, {8'h0, r});
    xfer(8'h00, r);
    check("test pin enable", 16'h0080, {8'h0, r});
    wr(HOST_CTRL_IDX, 8'h00);
    $display("read_reset done");
  endtask

  task automatic t_write_burst;
    logic [7:0] r;
    n_strobe = 0;
    wr(HOST_CTRL_IDX, 8'h01);
    xfer(8'h0a, r);
    xfer(8'h5a, r);
    xfer(8'ha5, r);
    wr(HOST_CTRL_IDX, 8'h00);
    check("write strobes", 16'h2, 16'(n_strobe));
    check("write addr", 16'h5, {10'h0, REG_WR_ADDR});
    check("write data", 16'ha5, {8'h0, REG_WR_DATA});
    dev_rd(6'h05, r);
    check("read back", 16'ha5, {8'h0, r});
    $display("write_burst done");
  endtask

  // an address byte left alone must not turn the next transfer into data
  // a known value first, so that a read turned into a write shows up
  task automatic t_cs_restart;
    logic [7:0] r;
    dev_wr(6'h06, 8'h3c);
    n_strobe = 0;
    wr(HOST_CTRL_IDX, 8'h01);
    xfer(8'h0c, r);
    wr(HOST_CTRL_IDX, 8'h00);
    dev_rd(6'h06, r);
    check("restart", 16'h003c, {8'h0, r});
    check("stray strobes", 16'h0, 16'(n_strobe));
    $display("cs_restart done");
  endtask

  task automatic ticks(input int cnt, output int n);
    int i;
    n = 0;
    for (i = 0; i < cnt; i++) begin
      @(negedge SYS_CLK);
      n++;
      while (BAUD_TICK !== 1'b1 && n < 9000) begin
        @(negedge SYS_CLK);
        n++;
      end
    end
  endtask

  task automatic t_baud;
    logic [7:0] tbl [3] = '{8'heb, 8'h7a, 8'h15};
    longint     per, exp;
    int         k, n;
    for (k = 0; k < 3; k++) begin
      if (k > 0) dev_wr(BAUD_DIV_ADDR, tbl[k]);
      per = (tbl[k][7:5] == 3'h0) ? tbl[k][4:0] + 1 : (tbl[k][4:0] + 33) << (tbl[k][7:5] - 1);
      exp = 4 * per * SYS_CLK_HZ / REF_CLK_HZ;
      ticks(2, n);
      ticks(4, n);
      // fractional ticks: four periods may span one cycle more
      check("baud span", 16'(exp), 16'(n - int'(n > exp)));
    end
    $display("baud done");
  endtask

  task automatic t_uart;
    logic [9:0] f, g;
    real        bitc;
    int         t, j;
    bitc = 22.0 * SYS_CLK_HZ / REF_CLK_HZ;
    check("request idle", 16'h1, {15'h0, UART_DATA_REQUEST});
    @(posedge SYS_CLK);
    TX_DATA  <= 8'h35;
    TX_VALID <= 1'b1;
    @(posedge SYS_CLK);
    TX_VALID <= 1'b0;
    for (t = 0; t < 40 && UART_TX !== 1'b0; t++) @(negedge SYS_CLK);
    check("ready busy", 16'h0, {15'h0, TX_READY});
    check("request busy", 16'h0, {15'h0, UART_DATA_REQUEST});
    t = 0;
    for (j = 0; j < 10; j++) begin
      while (t < int'((j + 0.5) * bitc)) begin
        @(negedge SYS_CLK);
        t++;
      end
      f[j] = UART_TX;
      g[j] = UART_MUX_OUTPUT;
    end
    check("uart frame", {6'h0, 1'b1, 8'h35, 1'b0}, {6'h0, f});
    check("mux frame", {6'h0, 1'b1, 8'h35, 1'b0}, {6'h0, g});
    dev_wr(TEST_PIN_EN_ADDR, 8'h00);
    repeat (3) @(negedge SYS_CLK);
    check("ready idle", 16'h1, {15'h0, TX_READY});
    check("request off", 16'h0, {15'h0, UART_DATA_REQUEST});
    check("mux off", 16'h0, {15'h0, UART_MUX_OUTPUT});
    $display("uart done");
  endtask

  task automatic end_of_test;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    repeat (12) @(posedge SYS_CLK);
    RST_N <= 1'b1;
    t_read_reset();
    t_write_burst();
    t_cs_restart();
    t_baud();
    t_uart();
    end_of_test();
  end

  // whole run needs well under a third of this
  initial begin
    #(100 * 40000);
    fail_count++;
    end_of_test();
  end
endmodule
